/* File: pkg/fcs_pkg.sv */
// shared constants and types of the flash command sequencer host
// assumes a byte-wide asynchronous parallel flash on the far side and one 40 MHz clock here
package fcs_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;

    // command addresses and codes
    localparam logic [ADDR_W-1:0] ADR_UNLOCK1  = 19'h00555;
    localparam logic [ADDR_W-1:0] ADR_UNLOCK2  = 19'h002aa;
    localparam logic [ADDR_W-1:0] ADR_PROT_LOW = 19'h00002;
    localparam int                PROT_SECT_LSB = 16;
    localparam logic [DATA_W-1:0] CMD_UNLOCK1     = 8'haa;
    localparam logic [DATA_W-1:0] CMD_UNLOCK2     = 8'h55;
    localparam logic [DATA_W-1:0] CMD_PROG_SETUP  = 8'ha0;
    localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [DATA_W-1:0] CMD_CHIP_ERASE  = 8'h10;
    localparam logic [DATA_W-1:0] CMD_AUTOSELECT  = 8'h90;
    localparam logic [DATA_W-1:0] CMD_RESET       = 8'hf0;
    localparam logic [DATA_W-1:0] ERASED_BYTE     = 8'hff;

    // status bit positions on the data pins
    localparam int DATA_POLLING_BIT     = 7;
    localparam int BUSY_TOGGLE_BIT      = 6;
    localparam int TIME_LIMIT_FAIL_FLAG = 5;
    localparam int ERASE_TOGGLE_BIT     = 2;

    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int GLITCH_NS     = 5;
    localparam int WE_LOW_NS     = 35;
    localparam int RD_ACC_NS     = 70;
    localparam int SYNC_STAGES   = 2;
    localparam int GLITCH_CYC    = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_LOW_RAW    = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_LOW_CYC    = (WE_LOW_RAW > GLITCH_CYC) ? WE_LOW_RAW : GLITCH_CYC + 1;
    localparam int RD_CYC        = (RD_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
    localparam logic [2:0] WE_LOW_LAST = 3'(WE_LOW_CYC - 1);
    localparam logic [2:0] RD_LAST     = 3'(RD_CYC - 1);

    typedef enum logic [2:0] {
        OP_READ        = 3'h0,
        OP_PROGRAM     = 3'h1,
        OP_CHIP_ERASE  = 3'h2,
        OP_ID_READ     = 3'h3,
        OP_PROT_VERIFY = 3'h4,
        OP_RESET       = 3'h5
    } fcs_op_t;

    typedef enum logic [1:0] {
        STEP_WRITE = 2'h0,
        STEP_READ  = 2'h1,
        STEP_POLL  = 2'h2
    } fcs_step_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_STEP   = 3'h1,
        ST_WSETUP = 3'h2,
        ST_WLOW   = 3'h3,
        ST_WHOLD  = 3'h4,
        ST_RLOW   = 3'h5,
        ST_DONE   = 3'h6
    } fcs_state_t;

    typedef struct packed {
        fcs_step_kind_t    kind;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic              last;
    } fcs_step_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic              dout_oe;
        logic              ce_n;
        logic              we_n;
        logic              oe_n;
    } fcs_pins_t;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
        logic              fail;
        logic              mismatch;
    } fcs_rsp_t;

    typedef struct packed {
        fcs_state_t        st;
        fcs_op_t           op;
        logic [2:0]        idx;
        logic [2:0]        cnt;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        fcs_step_t         step;
        logic [DATA_W-1:0] poll_prev;
        logic              have_prev;
        logic              fail;
        logic              mis;
        logic [DATA_W-1:0] last_rd;
        logic              ready;
        fcs_pins_t         pins;
        fcs_rsp_t          rsp;
        logic [DATA_W-1:0] sync1;
        logic [DATA_W-1:0] sync2;
    } fcs_host_state_t;
endpackage

/* File: design/fcs_host.sv */
// host-side controller that drives a parallel flash through its chip-select, strobe and data pins
// assumes the flash sits on the same board wiring; the bench resolves the data wire from dout_oe
//
// Behaviour
// - write only with select, strobe low, output high
// - single F0 write resets device
// - failure exits only through reset command
// - identification modes left by reset command
// - host sends only defined command codes
// - program is four unlock/setup/data writes
// - chip erase is six ordered writes
// - address and data stable across strobe
module fcs_host (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               arst_n,
    // user command port
    input  wire logic               cmd_valid,
    input  fcs_pkg::fcs_op_t        cmd_op,
    input  wire logic [18:0]        cmd_addr,
    input  wire logic [7:0]         cmd_data,
    output logic                    cmd_ready,
    output fcs_pkg::fcs_rsp_t       rsp,
    // flash pins
    output fcs_pkg::fcs_pins_t      flash_pins,
    input  wire logic [7:0]         dq_in
);
    fcs_pkg::fcs_host_state_t s_q;
    fcs_pkg::fcs_host_state_t s_d;
    fcs_pkg::fcs_step_t       nstep;
    logic [7:0]               sample;
    logic                     toggled;

    // one entry of the bus sequence of an operation
    function automatic fcs_pkg::fcs_step_t step_f(input fcs_pkg::fcs_op_t op, input logic [2:0] idx,
                                                  input logic [18:0] a, input logic [7:0] d);
        fcs_pkg::fcs_step_t u1;
        fcs_pkg::fcs_step_t u2;
        fcs_pkg::fcs_step_t rst;
        fcs_pkg::fcs_step_t r;
        u1  = '{fcs_pkg::STEP_WRITE, fcs_pkg::ADR_UNLOCK1, fcs_pkg::CMD_UNLOCK1, 1'b0};
        u2  = '{fcs_pkg::STEP_WRITE, fcs_pkg::ADR_UNLOCK2, fcs_pkg::CMD_UNLOCK2, 1'b0};
        rst = '{fcs_pkg::STEP_WRITE, a, fcs_pkg::CMD_RESET, 1'b1};
        r   = rst;
        unique case (op)
            fcs_pkg::OP_READ: r = '{fcs_pkg::STEP_READ, a, 8'h00, 1'b1};
            fcs_pkg::OP_RESET: r = rst;
            fcs_pkg::OP_PROGRAM: begin
                unique case (idx)
                    3'h0: r = u1;
                    3'h1: r = u2;
                    3'h2: r = '{fcs_pkg::STEP_WRITE, fcs_pkg::ADR_UNLOCK1, fcs_pkg::CMD_PROG_SETUP, 1'b0};
                    3'h3: r = '{fcs_pkg::STEP_WRITE, a, d, 1'b0};
                    default: r = '{fcs_pkg::STEP_POLL, a, d, 1'b1};
                endcase
            end
            fcs_pkg::OP_CHIP_ERASE: begin
                unique case (idx)
                    3'h0, 3'h3: r = u1;
                    3'h1, 3'h4: r = u2;
                    3'h2: r = '{fcs_pkg::STEP_WRITE, fcs_pkg::ADR_UNLOCK1, fcs_pkg::CMD_ERASE_SETUP, 1'b0};
                    3'h5: r = '{fcs_pkg::STEP_WRITE, fcs_pkg::ADR_UNLOCK1, fcs_pkg::CMD_CHIP_ERASE, 1'b0};
                    default: r = '{fcs_pkg::STEP_POLL, a, fcs_pkg::ERASED_BYTE, 1'b1};
                endcase
            end
            fcs_pkg::OP_ID_READ, fcs_pkg::OP_PROT_VERIFY: begin
                unique case (idx)
                    3'h0: r = u1;
                    3'h1: r = u2;
                    3'h2: r = '{fcs_pkg::STEP_WRITE, fcs_pkg::ADR_UNLOCK1, fcs_pkg::CMD_AUTOSELECT, 1'b0};
                    3'h3: begin
                        if (op == fcs_pkg::OP_ID_READ) begin
                            r = '{fcs_pkg::STEP_READ, a, 8'h00, 1'b0};
                        end else begin
                            r = '{fcs_pkg::STEP_READ, {a[18:fcs_pkg::PROT_SECT_LSB],
                                   fcs_pkg::ADR_PROT_LOW[fcs_pkg::PROT_SECT_LSB-1:0]}, 8'h00, 1'b0};
                        end
                    end
                    default: r = rst;
                endcase
            end
            default: r = rst;
        endcase
        return r;
    endfunction

    always_comb begin
        s_d     = s_q;
        nstep   = s_q.step;
        sample  = s_q.sync2;
        toggled = sample[fcs_pkg::BUSY_TOGGLE_BIT] != s_q.poll_prev[fcs_pkg::BUSY_TOGGLE_BIT];
        s_d.rsp.valid = 1'b0;
        s_d.sync1     = dq_in;
        s_d.sync2     = s_q.sync1;
        unique case (s_q.st)
            fcs_pkg::ST_IDLE: begin
                s_d.ready = 1'b1;
                if (cmd_valid && s_q.ready) begin
                    s_d.ready     = 1'b0;
                    s_d.op        = cmd_op;
                    s_d.addr      = cmd_addr;
                    s_d.data      = cmd_data;
                    s_d.idx       = 3'h0;
                    s_d.fail      = 1'b0;
                    s_d.mis       = 1'b0;
                    s_d.have_prev = 1'b0;
                    s_d.last_rd   = 8'h00;
                    s_d.st        = fcs_pkg::ST_STEP;
                end
            end
            fcs_pkg::ST_STEP: begin
                nstep = step_f(s_q.op, s_q.idx, s_q.addr, s_q.data);
                if (s_q.fail) begin
                    nstep = '{fcs_pkg::STEP_WRITE, s_q.addr, fcs_pkg::CMD_RESET, 1'b1};
                end
                s_d.step      = nstep;
                s_d.pins.addr = nstep.addr;
                s_d.cnt       = 3'h0;
                if (nstep.kind == fcs_pkg::STEP_WRITE) begin
                    s_d.pins.oe_n    = 1'b1;
                    s_d.pins.dout    = nstep.data;
                    s_d.pins.dout_oe = 1'b1;
                    s_d.st           = fcs_pkg::ST_WSETUP;
                end else begin
                    s_d.pins.ce_n = 1'b0;
                    s_d.pins.oe_n = 1'b0;
                    s_d.st        = fcs_pkg::ST_RLOW;
                end
            end
            fcs_pkg::ST_WSETUP: begin
                // address and data already stable one cycle before the strobe falls
                s_d.pins.ce_n = 1'b0;
                s_d.pins.we_n = 1'b0;
                s_d.st        = fcs_pkg::ST_WLOW;
            end
            fcs_pkg::ST_WLOW: begin
                s_d.cnt = s_q.cnt + 3'h1;
                if (s_q.cnt == fcs_pkg::WE_LOW_LAST) begin
                    s_d.pins.ce_n = 1'b1;
                    s_d.pins.we_n = 1'b1;
                    s_d.st        = fcs_pkg::ST_WHOLD;
                end
            end
            fcs_pkg::ST_WHOLD: begin
                s_d.pins.dout_oe = 1'b0;
                s_d.idx          = s_q.idx + 3'h1;
                s_d.st           = s_q.step.last ? fcs_pkg::ST_DONE : fcs_pkg::ST_STEP;
            end
            fcs_pkg::ST_RLOW: begin
                s_d.cnt = s_q.cnt + 3'h1;
                if (s_q.cnt == fcs_pkg::RD_LAST) begin
                    s_d.pins.ce_n = 1'b1;
                    s_d.pins.oe_n = 1'b1;
                    s_d.st        = fcs_pkg::ST_STEP;
                    if (s_q.step.kind == fcs_pkg::STEP_READ) begin
                        s_d.last_rd = sample;
                        s_d.idx     = s_q.idx + 3'h1;
                        s_d.st      = s_q.step.last ? fcs_pkg::ST_DONE : fcs_pkg::ST_STEP;
                    end else if (!s_q.have_prev) begin
                        s_d.poll_prev = sample;
                        s_d.have_prev = 1'b1;
                    end else if (!toggled) begin
                        s_d.last_rd = sample;
                        s_d.st      = fcs_pkg::ST_DONE;
                        if (s_q.op == fcs_pkg::OP_PROGRAM) begin
                            s_d.mis = |(sample & ~s_q.data);
                        end else begin
                            s_d.mis = (sample != fcs_pkg::ERASED_BYTE)
                                      || !sample[fcs_pkg::DATA_POLLING_BIT];
                        end
                    end else if (sample[fcs_pkg::TIME_LIMIT_FAIL_FLAG]) begin
                        s_d.fail = 1'b1;
                    end else begin
                        s_d.poll_prev = sample;
                    end
                end
            end
            fcs_pkg::ST_DONE: begin
                s_d.rsp.valid    = 1'b1;
                s_d.rsp.data     = s_q.last_rd;
                s_d.rsp.fail     = s_q.fail;
                s_d.rsp.mismatch = s_q.mis;
                s_d.st           = fcs_pkg::ST_IDLE;
            end
            default: s_d.st = fcs_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q              <= '0;
            s_q.pins.ce_n    <= 1'b1;
            s_q.pins.we_n    <= 1'b1;
            s_q.pins.oe_n    <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign cmd_ready  = s_q.ready;
    assign rsp        = s_q.rsp;
    assign flash_pins = s_q.pins;

    write_gate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        !s_q.pins.we_n |-> !s_q.pins.ce_n && s_q.pins.oe_n && s_q.pins.dout_oe)
        else $error("strobe low without select or with output enabled");
    read_bus_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        !s_q.pins.oe_n |-> s_q.pins.we_n && !s_q.pins.dout_oe)
        else $error("read overlaps a write or data drive");
    pulse_width_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        $fell(s_q.pins.we_n) |-> !s_q.pins.we_n [*2] ##1 s_q.pins.we_n)
        else $error("write pulse width wrong");
    idle_quiet_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_q.st == fcs_pkg::ST_IDLE |-> s_q.pins.we_n && s_q.pins.ce_n)
        else $error("strobe active while idle");
    busy_refuse_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_q.ready |-> s_q.st == fcs_pkg::ST_IDLE)
        else $error("command accepted while busy");
    prog_setup_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_q.st == fcs_pkg::ST_WLOW && s_q.op == fcs_pkg::OP_PROGRAM && s_q.idx == 3'h2 && !s_q.fail
        |-> s_q.pins.dout == fcs_pkg::CMD_PROG_SETUP && s_q.pins.addr == fcs_pkg::ADR_UNLOCK1)
        else $error("program setup cycle wrong");
    erase_last_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_q.st == fcs_pkg::ST_WLOW && s_q.op == fcs_pkg::OP_CHIP_ERASE && s_q.idx == 3'h5 && !s_q.fail
        |-> s_q.pins.dout == fcs_pkg::CMD_CHIP_ERASE && s_q.pins.addr == fcs_pkg::ADR_UNLOCK1)
        else $error("chip erase final cycle wrong");
    full_seq_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_q.st == fcs_pkg::ST_RLOW && s_q.step.kind == fcs_pkg::STEP_POLL
        |-> (s_q.op == fcs_pkg::OP_PROGRAM && s_q.idx == 3'h4)
            || (s_q.op == fcs_pkg::OP_CHIP_ERASE && s_q.idx == 3'h6))
        else $error("polling before the sequence completed");
    fail_reset_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(s_q.fail) |-> ##[1:3] (s_q.st == fcs_pkg::ST_WSETUP && s_q.pins.dout == fcs_pkg::CMD_RESET))
        else $error("failure not followed by reset command");
    poll_no_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_q.step.kind == fcs_pkg::STEP_POLL && !s_q.fail |-> s_q.pins.we_n)
        else $error("write issued while operation running");
endmodule

/* File: verification/fcs_flash_model.sv */
// behavioural byte-wide flash device seen from the host's pins
// assumes the bench resolves the data wire and sets the strap inputs
module fcs_flash_model (
    // bus pins
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic [18:0] addr,
    input  wire logic [7:0]  din,
    output logic [7:0]       dq_out,
    // straps from the bench
    input  wire logic [3:0]  busy_len,
    input  wire logic        fail_en,
    input  wire logic [7:0]  prot_mask,
    output logic             viol
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [7:0] MAKER_ID  = 8'h3c; // arbitrary value
    localparam logic [7:0] DEVICE_ID = 8'h5a; // arbitrary value

    logic [7:0]  mem [logic [18:0]];
    logic [7:0]  dq_q = 8'h00;
    logic [7:0]  v, fin, pd;
    logic [18:0] pa, wa;
    logic [2:0]  cyc  = 3'h0;
    logic [2:0]  mode = 3'h0; // 0 array, 1 id, 3 busy, 7 failed
    logic        drv  = 1'b0;
    logic        skip = 1'b0;
    logic        tgl, er, pp;
    int          left;
    time         t_fall;
    // select and strobe move in one time step, so cycle edges come from their combination
    wire logic   wr_act = !ce_n && !we_n && oe_n;
    wire logic   rd_act = !ce_n && !oe_n && we_n;

    // a released wire shows the inverse of the last value
    assign dq_out = drv ? dq_q : ~dq_q;

    initial begin
        viol = 1'b0;
        #1;
        skip = we_n === 1'b0 && ce_n === 1'b0 && oe_n === 1'b1;
    end

    function automatic logic [7:0] rd(input logic [18:0] a);
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction

    // toggle phase chosen so the last status read matches the final byte
    task automatic start(input int n);
        left = n;
        tgl  = fin[6] ^ n[0];
        mode = 3'h3;
        cyc  = 3'h0;
    endtask

    // address is taken at the later falling edge of select and strobe
    always @(posedge wr_act) begin
        t_fall = $time;
        wa     = addr;
    end

    // data is taken at the earlier rising edge
    always @(negedge wr_act) begin
        if ($time - t_fall >= 5) begin
            if (skip) skip = 1'b0;
            else if (mode == 3'h3) viol = 1'b1;
            else if (din == 8'hf0) begin
                mode = 3'h0;
                cyc  = 3'h0;
            end else if (mode != 3'h0) viol = 1'b1;
            else if (cyc == 3'h3) begin
                pa  = wa;
                pd  = din;
                er  = 1'b0;
                pp  = prot_mask[wa[18:16]];
                fin = pp ? rd(wa) : rd(wa) & din;
                start(pp ? 1 : int'(busy_len));
            end else if (cyc == 3'h6 && wa == 19'h00555 && din == 8'h10) begin
                er  = 1'b1;
                fin = 8'hff;
                start(int'(busy_len));
            end else if ((cyc == 3'h0 || cyc == 3'h4) && wa == 19'h00555 && din == 8'haa) cyc++;
            else if ((cyc == 3'h1 || cyc == 3'h5) && wa == 19'h002aa && din == 8'h55) cyc++;
            else if (cyc == 3'h2 && wa == 19'h00555 && din == 8'ha0) cyc = 3'h3;
            else if (cyc == 3'h2 && wa == 19'h00555 && din == 8'h80) cyc = 3'h4;
            else if (cyc == 3'h2 && wa == 19'h00555 && din == 8'h90) mode = 3'h1;
            else viol = 1'b1;
        end
    end

    // the address settles in the same time step as select, so it is looked at after the access time
    always @(posedge rd_act) begin
        #40;
        if (rd_act) begin
            if (mode == 3'h1 && addr[1]) v = {7'h0, prot_mask[addr[18:16]]};
            else if (mode == 3'h1) v = addr[0] ? DEVICE_ID : MAKER_ID;
            else if (mode == 3'h0) v = rd(addr);
            else begin
                tgl = ~tgl;
                v = er ? {1'b0, tgl, mode[2], 2'h0, tgl, 2'h0} : {~pd[7], tgl, mode[2], 5'h0};
                left--;
                if (mode == 3'h3 && left == 0) begin
                    mode = fail_en ? 3'h7 : 3'h0;
                    if (!fail_en && er) mem.delete();
                    else if (!fail_en && !pp) mem[pa] = fin;
                end
            end
            dq_q = v;
            drv  = 1'b1;
        end
    end

    always @(negedge rd_act) drv = 1'b0;
endmodule

/* File: verification/fcs_host_test.sv */
// self-checking bench of fcs_host against the behavioural flash model
// assumes fcs_pkg and the design compile first; the data wire is resolved here
module fcs_host_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic               core_clk  = 1'b0;
    logic               arst_n    = 1'b0;
    logic               cmd_valid = 1'b0;
    fcs_pkg::fcs_op_t   cmd_op    = fcs_pkg::OP_READ;
    logic [18:0]        cmd_addr  = 19'h0;
    logic [7:0]         cmd_data  = 8'h00;
    logic [3:0]         busy_len  = 4'h2;
    logic               fail_en   = 1'b0;
    logic [7:0]         prot_mask = 8'h24;
    logic [31:0]        seed      = 32'd81;
    logic               cmd_ready, viol;
    logic [7:0]         dq_dev;
    fcs_pkg::fcs_rsp_t  rsp;
    fcs_pkg::fcs_pins_t pins;
    wire logic [7:0]    dq_in = pins.dout_oe ? pins.dout : dq_dev;
    logic [7:0]         exp_mem [logic [18:0]];
    int                 failures = 0;
    int                 checks   = 0;

    fcs_host fcs_host_inst (.core_clk(core_clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp(rsp), .flash_pins(pins),
        .dq_in(dq_in));
    fcs_flash_model fcs_flash_model_inst (.ce_n(pins.ce_n), .we_n(pins.we_n), .oe_n(pins.oe_n),
        .addr(pins.addr), .din(pins.dout), .dq_out(dq_dev), .busy_len(busy_len), .fail_en(fail_en),
        .prot_mask(prot_mask), .viol(viol));

    always #12.5 core_clk = ~core_clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] exp_rd(input logic [18:0] a);
        return exp_mem.exists(a) ? exp_mem[a] : 8'hff;
    endfunction

    task automatic final_report();
        if (failures == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    // one request, raised once ready and held one cycle, then wait for the answer
    task automatic run(input fcs_pkg::fcs_op_t op, input logic [18:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(posedge core_clk);
            #2;
            n++;
        end
        cmd_op    = op;
        cmd_addr  = a;
        cmd_data  = d;
        cmd_valid = 1'b1;
        @(posedge core_clk);
        #2;
        cmd_valid = 1'b0;
        chk_flag(cmd_ready, 1'b0);
        n = 0;
        while (rsp.valid !== 1'b1 && n < 4000) begin
            @(posedge core_clk);
            #2;
            n++;
        end
        if (n >= 4000) chk_flag(1'b0, 1'b1);
    endtask

    task automatic rd_chk(input logic [18:0] a);
        run(fcs_pkg::OP_READ, a, 8'h00);
        chk_byte(rsp.data, exp_rd(a));
    endtask

    initial begin
        #2000000;
        failures++;
        final_report();
    end

    initial begin
        logic [31:0] r;
        logic [18:0] a;
        logic [7:0]  d;
        repeat (2) @(posedge core_clk);
        #2;
        arst_n = 1'b1;
        rd_chk(19'h00777);
        // odd passes reprogram the same byte
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            // the first pass always lands in a protected sector
            if (!i[0]) a = (i == 0) ? {3'h2, r[15:0]} : r[18:0];
            d = r[26:19];
            busy_len = 4'h2 + 4'(r[31:29]);
            run(fcs_pkg::OP_PROGRAM, a, d);
            if (!prot_mask[a[18:16]]) exp_mem[a] = exp_rd(a) & d;
            chk_flag(rsp.fail, 1'b0);
            chk_byte(rsp.data, exp_rd(a));
            chk_flag(rsp.mismatch, |(~d & exp_rd(a)));
            rd_chk(a);
        end
        fail_en = 1'b1;
        run(fcs_pkg::OP_PROGRAM, 19'h7ffff, 8'h00);
        chk_flag(rsp.fail, 1'b1);
        fail_en = 1'b0;
        rd_chk(19'h7ffff);
        for (int i = 0; i < 2; i++) begin
            run(fcs_pkg::OP_ID_READ, 19'(i), 8'h00);
            chk_byte(rsp.data, i ? 8'h5a : 8'h3c);
            rd_chk(a);
        end
        for (int s = 0; s < 8; s++) begin
            run(fcs_pkg::OP_PROT_VERIFY, {3'(s), 16'h0000}, 8'h00);
            chk_byte(rsp.data, {7'h0, prot_mask[s]});
        end
        run(fcs_pkg::OP_RESET, 19'h12345, 8'h00);
        run(fcs_pkg::fcs_op_t'(3'h6), 19'h00000, 8'h00);
        rd_chk(a);
        fail_en = 1'b1;
        run(fcs_pkg::OP_CHIP_ERASE, 19'h00000, 8'h00);
        chk_flag(rsp.fail, 1'b1);
        fail_en = 1'b0;
        rd_chk(a);
        run(fcs_pkg::OP_CHIP_ERASE, a, 8'h00);
        chk_flag(rsp.fail, 1'b0);
        chk_flag(rsp.mismatch, 1'b0);
        exp_mem.delete();
        rd_chk(a);
        chk_flag(viol, 1'b0);
        final_report();
    end
endmodule
